// ---- include/measure_timer_defs.vh ----
`ifndef MEASURE_TIMER_DEFS_VH
`define MEASURE_TIMER_DEFS_VH

// ==========================================================================
// register byte addresses
`define MT_CTRL0_ADDR    12'h0498
`define MT_PERIOD_ADDR   12'h049C
`define MT_COUNT_ADDR    12'h04A0
`define MT_STATUS_ADDR   12'h04A4
`define MT_MASK_ADDR     12'h04A8

// ==========================================================================
// control register 0 fields
`define MT_CTRL0_EN      7
`define MT_CTRL0_HALT    5
`define MT_CTRL0_WINDOW_POLARITY    4
`define MT_CTRL0_SIGNAL_POLARITY    3
`define MT_CTRL0_COUNT_EDGE_SELECT    2
`define MT_CTRL0_PS_HI   1
`define MT_CTRL0_PS_LO   0
`define MT_CTRL0_MASK    8'hBF
`define MT_CTRL0_RESET   8'h00

// ==========================================================================
// status and mask fields
`define MT_ST_PERIOD     0
`define MT_ST_WIN        1
`define MT_ST_SIG        2
`define MT_ST_BITS       3
`define MT_PERIOD_RESET  24'hFF_FFFF

`endif

// ---- logic/count_prescaler.v ----
`timescale 1ns/1ps
`default_nettype none

// ==========================================================================
// prescaler: passes one in 1, 2, 4 or 8 edge events
module count_prescaler (
  input  wire       pclk,
  input  wire       presetn,
  input  wire       clear,
  input  wire       edge_in,
  input  wire [1:0] sel,
  output reg        tick
);

  reg  [2:0] div_r;
  reg  [2:0] lim;

  // last count value before a tick, per select code
  always @* begin
    case (sel)
      2'b00:   lim = 3'd0;
      2'b01:   lim = 3'd1;
      2'b10:   lim = 3'd3;
      2'b11:   lim = 3'd7;
      default: lim = 3'd0;
    endcase
  end

  // divide counter and registered tick
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_r <= 3'd0;
      tick  <= 1'b0;
    end else if (clear) begin
      div_r <= 3'd0;
      tick  <= 1'b0;
    end else begin
      tick <= 1'b0;
      if (edge_in) begin
        if (div_r >= lim) begin
          div_r <= 3'd0;
          tick  <= 1'b1;
        end else begin
          div_r <= div_r + 3'd1;
        end
      end
    end
  end

endmodule // count_prescaler

`default_nettype wire

// ---- logic/signal_measure_timer.v ----
`timescale 1ns/1ps
`default_nettype none
`include "measure_timer_defs.vh"

// ==========================================================================
// Operation
// - Enable one runs the timer; zero resets the count, prescaler and edge history, keeps the status bits, and drops the clock request.
// - With halt set the count stays at the period value on match and the match interrupt fires when clocked.
// - With halt clear the count returns to zero on match and the match interrupt still fires when clocked.
// - Window polarity one reads the window active-low on falling edges, zero active-high on rising edges.
// - Signal polarity one reads the signal active-low on falling edges, zero active-high on rising edges.
// - Count edge select one counts on falling edges of the selected clock, zero on rising edges.
// - Prescale codes 00, 01, 10, 11 divide the counting clock by 1, 2, 4, 8.
module signal_measure_timer #(
  parameter CW = 24
) (
  input  wire          pclk,
  input  wire          presetn,
  input  wire          psel,
  input  wire          penable,
  input  wire          pwrite,
  input  wire [11:0]   paddr,
  input  wire [31:0]   pwdata,
  output reg  [31:0]   prdata,
  output reg           pready,
  output reg           pslverr,
  input  wire          count_clock,
  input  wire          window_input,
  input  wire          signal_input,
  output reg           clock_request,
  output reg           window_active,
  output reg           signal_active,
  output reg           irq
);

  // ========================================================================
  // registers
  reg  [7:0]              ctrl_r;
  reg  [CW-1:0]           period_r;
  reg  [CW-1:0]           count_r;
  reg  [`MT_ST_BITS-1:0]  status_r;
  reg  [`MT_ST_BITS-1:0]  mask_r;
  reg                     clk_prev_r;
  reg                     win_prev_r;
  reg                     sig_prev_r;
  reg  [`MT_ST_BITS-1:0]  status_nxt;
  reg  [CW-1:0]           count_nxt;
  reg                     match_ev;

  wire                    en;
  wire                    halt;
  wire                    window_polarity;
  wire                    signal_polarity;
  wire                    count_edge_select;
  wire [1:0]              ps;
  wire                    wr;
  wire                    rd;
  wire                    clk_lvl;
  wire                    win_lvl;
  wire                    sig_lvl;
  wire                    clk_edge;
  wire                    win_edge;
  wire                    sig_edge;
  wire                    tick;

  assign en   = ctrl_r[`MT_CTRL0_EN];
  assign halt = ctrl_r[`MT_CTRL0_HALT];
  assign window_polarity = ctrl_r[`MT_CTRL0_WINDOW_POLARITY];
  assign signal_polarity = ctrl_r[`MT_CTRL0_SIGNAL_POLARITY];
  assign count_edge_select = ctrl_r[`MT_CTRL0_COUNT_EDGE_SELECT];
  assign ps   = ctrl_r[`MT_CTRL0_PS_HI:`MT_CTRL0_PS_LO];

  // apb strobes: a write lands on the edge that sees pready high,
  // a read loads prdata one edge earlier so it stands with pready
  assign wr = psel & penable & pwrite & pready;
  assign rd = psel & penable & ~pwrite & ~pready;

  // decide whether the named address is mapped
  function mapped;
    input [11:0] a;
    begin
      mapped = (a == `MT_CTRL0_ADDR) || (a == `MT_PERIOD_ADDR) ||
               (a == `MT_COUNT_ADDR) || (a == `MT_STATUS_ADDR) ||
               (a == `MT_MASK_ADDR);
    end
  endfunction

  // ========================================================================
  // input polarity
  // count edge
  assign clk_lvl = count_clock ^ count_edge_select;
  assign win_lvl = window_input ^ window_polarity;
  assign sig_lvl = signal_input ^ signal_polarity;

  assign clk_edge = en & clk_lvl & ~clk_prev_r;
  assign win_edge = en & win_lvl & ~win_prev_r;
  assign sig_edge = en & sig_lvl & ~sig_prev_r;

  // previous levels, set to one while disabled
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_prev_r <= 1'b0;
      win_prev_r <= 1'b0;
      sig_prev_r <= 1'b0;
    end else if (!en) begin
      clk_prev_r <= 1'b1;
      win_prev_r <= 1'b1;
      sig_prev_r <= 1'b1;
    end else begin
      clk_prev_r <= clk_lvl;
      win_prev_r <= win_lvl;
      sig_prev_r <= sig_lvl;
    end
  end

  // ========================================================================
  // prescaler
  // prescale divide
  count_prescaler u_pre (
    .pclk    (pclk),
    .presetn (presetn),
    .clear   (~en),
    .edge_in (clk_edge),
    .sel     (ps),
    .tick    (tick)
  );

  // ========================================================================
  // counter next value and match event
  always @* begin
    count_nxt = count_r;
    match_ev  = 1'b0;
    if (tick) begin
      if (count_r == period_r) begin
        match_ev = 1'b1;
        if (halt)
          count_nxt = period_r;
        else
          count_nxt = {CW{1'b0}};
      end else begin
        count_nxt = count_r + {{(CW-1){1'b0}}, 1'b1};
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_r       <= {CW{1'b0}};
      clock_request <= 1'b0;
      window_active <= 1'b0;
      signal_active <= 1'b0;
    end else if (!en) begin
      count_r       <= {CW{1'b0}};
      clock_request <= 1'b0;
      window_active <= 1'b0;
      signal_active <= 1'b0;
    end else begin
      count_r       <= count_nxt;
      clock_request <= 1'b1;
      window_active <= win_lvl;
      signal_active <= sig_lvl;
    end
  end

  // ========================================================================
  // sticky status, write one to clear, set wins
  always @* begin
    status_nxt = status_r;
    if (wr && paddr == `MT_STATUS_ADDR)
      status_nxt = status_r & ~pwdata[`MT_ST_BITS-1:0];
    status_nxt[`MT_ST_PERIOD] = status_nxt[`MT_ST_PERIOD] | match_ev;
    status_nxt[`MT_ST_WIN]    = status_nxt[`MT_ST_WIN] | win_edge;
    status_nxt[`MT_ST_SIG]    = status_nxt[`MT_ST_SIG] | sig_edge;
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_r <= {`MT_ST_BITS{1'b0}};
      irq      <= 1'b0;
    end else begin
      status_r <= status_nxt;
      irq      <= |(status_nxt & mask_r);
    end
  end

  // ========================================================================
  // register writes
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r   <= `MT_CTRL0_RESET;
      period_r <= `MT_PERIOD_RESET;
      mask_r   <= {`MT_ST_BITS{1'b0}};
    end else if (wr) begin
      case (paddr)
        `MT_CTRL0_ADDR:  ctrl_r   <= pwdata[7:0] & `MT_CTRL0_MASK;
        `MT_PERIOD_ADDR: period_r <= pwdata[CW-1:0];
        `MT_MASK_ADDR:   mask_r   <= pwdata[`MT_ST_BITS-1:0];
        default:         ctrl_r   <= ctrl_r;
      endcase
    end
  end

  // ========================================================================
  // apb answer, one wait state in each access
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~mapped(paddr);
      if (rd) begin
        case (paddr)
          `MT_CTRL0_ADDR:  prdata <= {24'h00_0000, ctrl_r};
          `MT_PERIOD_ADDR: prdata <= {{(32-CW){1'b0}}, period_r};
          `MT_COUNT_ADDR:  prdata <= {{(32-CW){1'b0}}, count_r};
          `MT_STATUS_ADDR: prdata <= {{(32-`MT_ST_BITS){1'b0}}, status_r};
          `MT_MASK_ADDR:   prdata <= {{(32-`MT_ST_BITS){1'b0}}, mask_r};
          default:         prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule // signal_measure_timer

`default_nettype wire

// ---- verif/signal_measure_timer_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "measure_timer_defs.vh"
// ==========================================
// port checker of the measurement timer
module signal_measure_timer_sva (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        count_clock,
  input wire logic        window_input,
  input wire logic        signal_input,
  input wire logic        clock_request,
  input wire logic        window_active,
  input wire logic        signal_active,
  input wire logic        irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // finished transfer, control write, decoded address
  wire logic done = psel && penable && pready;
  wire logic wr_ctl = done && pwrite && paddr == `MT_CTRL0_ADDR;
  wire logic mapped = paddr inside {`MT_CTRL0_ADDR, `MT_PERIOD_ADDR,
    `MT_COUNT_ADDR, `MT_STATUS_ADDR, `MT_MASK_ADDR};
  logic [7:0] ctl_r;
  // copy of the control value software wrote
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) ctl_r <= 8'h00;
    else if (wr_ctl) ctl_r <= pwdata[7:0];
  sequence s_wait; psel && penable && !pready; endsequence
  sequence s_steady; clock_request && $stable(window_input) &&
    $stable(signal_input) && $stable(ctl_r); endsequence
  property p_one_wait; s_wait |=> pready; endproperty
  property p_pulse; pready |=> !pready; endproperty
  property p_err_ack; pslverr |-> pready; endproperty
  property p_unmapped; done |-> pslverr == !mapped; endproperty
  property p_ctl_read; done && !pwrite && paddr == `MT_CTRL0_ADDR
    |-> prdata == {24'h0, ctl_r & `MT_CTRL0_MASK}; endproperty
  property p_enable; wr_ctl && pwdata[7] |-> ##[0:2] clock_request;
  endproperty
  property p_disable; wr_ctl && !pwdata[7]
    |-> ##2 !(clock_request || window_active || signal_active); endproperty
  property p_polarity; s_steady [*4] |->
    window_active == (window_input ^ ctl_r[`MT_CTRL0_WINDOW_POLARITY]) &&
    signal_active == (signal_input ^ ctl_r[`MT_CTRL0_SIGNAL_POLARITY]); endproperty
  a_one_wait: assert property (p_one_wait) else $error("late pready");
  a_pulse: assert property (p_pulse) else $error("pready too long");
  a_err_ack: assert property (p_err_ack) else $error("lone pslverr");
  a_unmapped: assert property (p_unmapped) else $error("bad pslverr");
  a_ctl_read: assert property (p_ctl_read) else $error("ctrl read");
  a_enable: assert property (p_enable) else $error("no request");
  a_disable: assert property (p_disable) else $error("not idle");
  a_polarity: assert property (p_polarity) else $error("pol");
endmodule // signal_measure_timer_sva
bind signal_measure_timer signal_measure_timer_sva i_sva (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .count_clock(count_clock),
  .window_input(window_input), .signal_input(signal_input),
  .clock_request(clock_request), .window_active(window_active),
  .signal_active(signal_active), .irq(irq));
`default_nettype wire

// ---- verif/measure_signal_source.sv ----
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// far side: counting clock, window and signal
module measure_signal_source (
  input  wire logic pclk,
  output var logic  count_clock,
  output var logic  window_input,
  output var logic  signal_input
);
  // idle low, the clock stands still between bursts
  initial begin
    count_clock = 1'b0;
    window_input = 1'b0;
    signal_input = 1'b0;
  end
  task automatic toggle(input int n);
    repeat (n) begin
      repeat (4) @(posedge pclk);
      count_clock <= ~count_clock;
    end
    repeat (4) @(posedge pclk);
  endtask
  // set both levels, then let them settle
  task automatic lines(input logic w, input logic s);
    @(posedge pclk);
    window_input <= w;
    signal_input <= s;
    repeat (4) @(posedge pclk);
  endtask
endmodule // measure_signal_source
`default_nettype wire

// ---- verif/signal_measure_timer_test.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "measure_timer_defs.vh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
  error_cnt++; $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
// ==========================================
// self-checking bench of the measurement timer
module signal_measure_timer_test;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        count_clock, window_input, signal_input, irq;
  logic        clock_request, window_active, signal_active;
  logic [32:0] q[$], ex;
  logic [7:0]  r;
  int          error_cnt, n_compared, cyc;
  signal_measure_timer i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .count_clock(count_clock),
    .window_input(window_input), .signal_input(signal_input),
    .clock_request(clock_request), .window_active(window_active),
    .signal_active(signal_active), .irq(irq));
  measure_signal_source i_src (.pclk(pclk), .count_clock(count_clock),
    .window_input(window_input), .signal_input(signal_input));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // one transfer; the expected answer is noted first
  task automatic apb(input logic [11:0] a, input logic w,
                     input logic [31:0] d, input logic [32:0] e);
    @(posedge pclk);
    q.push_back(e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (!pready);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(a, 1'b1, d, 33'h0);
  endtask
  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    apb(a, 1'b0, 32'h0, e);
  endtask
  task tally_and_finish;
    $display("compared %0d errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // compare each finished transfer with the oldest note
  always @(posedge pclk)
    if (psel && penable && pready) begin
      ex = q.pop_front();
      `CHK("apb", ex, {pslverr, pwrite ? 32'h0 : prdata})
    end
  // cut a hang short
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 30000) begin
      error_cnt++;
      tally_and_finish;
    end
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    void'($urandom(9));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rd(`MT_CTRL0_ADDR, 33'h0);
    rd(`MT_PERIOD_ADDR, 33'h0_00ff_ffff);
    rd(`MT_STATUS_ADDR, 33'h0);
    apb(12'h04ac, 1'b1, 32'hffff_ffff, 33'h1_0000_0000);
    rd(12'h04ac, 33'h1_0000_0000);
    r = 8'($urandom);
    wr(`MT_CTRL0_ADDR, {24'h0, r & 8'h7f});
    rd(`MT_CTRL0_ADDR, {25'h0, r & 8'h3f});
    wr(`MT_CTRL0_ADDR, 32'h0000_00ff);
    rd(`MT_CTRL0_ADDR, 33'h0_0000_00bf);
    // every prescale code on both counting edges
    for (int i = 0; i < 8; i++) begin
      wr(`MT_CTRL0_ADDR, 32'h0);
      rd(`MT_COUNT_ADDR, 33'h0);
      if (count_clock) i_src.toggle(1);
      wr(`MT_CTRL0_ADDR, {24'h0, 5'h10, 3'(i)});
      i_src.toggle(17);
      rd(`MT_COUNT_ADDR, 33'((i[2] ? 8 : 9) >> i[1:0]));
    end
    // halt or wrap at the period value; mask gates irq
    for (int h = 0; h < 2; h++) begin
      wr(`MT_CTRL0_ADDR, 32'h0);
      wr(`MT_PERIOD_ADDR, 32'h0000_0003);
      wr(`MT_MASK_ADDR, 32'(h));
      wr(`MT_CTRL0_ADDR, {24'h0, 2'b10, 1'(h), 5'h0});
      i_src.toggle(10);
      rd(`MT_COUNT_ADDR, h ? 33'h3 : 33'h1);
      rd(`MT_STATUS_ADDR, 33'h1);
      `CHK("irq", 1'(h), irq)
      wr(`MT_STATUS_ADDR, 32'h0000_0001);
      rd(`MT_STATUS_ADDR, 33'h0);
      `CHK("irq", 1'b0, irq)
    end
    // window and signal edges under every polarity pair
    for (int p = 0; p < 4; p++) begin
      wr(`MT_CTRL0_ADDR, 32'h0);
      wr(`MT_STATUS_ADDR, 32'h0000_0007);
      wr(`MT_CTRL0_ADDR, {24'h0, 3'b100, 2'(p), 3'h0});
      i_src.lines(1'b1, 1'b1);
      rd(`MT_STATUS_ADDR, {30'h0, !p[0], !p[1], 1'b0});
      i_src.lines(1'b0, 1'b0);
      rd(`MT_STATUS_ADDR, 33'h6);
    end
    tally_and_finish;
  end
endmodule // signal_measure_timer_test
`default_nettype wire
